// [hte_pkg.sv]
// Constants, register map and types of the hardware trigger exposure control
// Summary of operation
// - Both exposure schemes work only when frame start comes from the external trigger line.
// - Timed scheme exposes exactly the programmed duration, whatever the trigger width.
// - Timed scheme starts on the rising or the falling edge as selected.
// - A trigger edge during a running exposure is dropped and flags overtrigger.
// - Pulse-width scheme exposes from the active edge to the opposite edge.
// - Pulse-width scheme drives frame trigger wait from the overlap time maximum.
// - Offset variants add a fixed sensor offset to the trigger-controlled period.
// - The fixed offset is a per-variant constant, set by a parameter.
// - The fixed offset only extends the end, never moves the exposure start.
// - Automatic overlap mode forces overlap maximum to its top and rejects writes.
// - Manual overlap mode accepts and applies written overlap maximum values.
// - The overlap mode selector exists only on variants with a general-purpose line.
// - On such variants pulse-width scheme is selectable only after trigger mode and source.
// - Edge polarity select chooses rising or falling trigger edge for frame start.
// - Triggers are taken only while waiting; waiting resumes when exposure is over.
package hte_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DUR_W = 24;
    localparam int unsigned PRESC_W = 16;
    localparam int unsigned STAT_W = 3;

    // ************************************************************
    // Register offsets (byte addresses)
    // ************************************************************
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_EXPOSURE = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_OVERLAP = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_PRESCALE = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_MASK = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_STATE = 8'h18;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int unsigned STAT_OVERTRIG = 0;
    localparam int unsigned STAT_EXP_START = 1;
    localparam int unsigned STAT_EXP_END = 2;
    localparam logic [DUR_W-1:0] EXPOSURE_RST = 24'h0003e8;
    localparam logic [DUR_W-1:0] OVERLAP_MAX = 24'hffffff;
    localparam logic [STAT_W-1:0] MASK_RST = 3'h0;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int unsigned TICK_TIME_US = 1;
    localparam int unsigned CLK_FREQ_MHZ = 200;
    localparam logic [PRESC_W-1:0] PRESC_RST = PRESC_W'(TICK_TIME_US * CLK_FREQ_MHZ - 1);
    localparam int unsigned OFFSET_US_DEF = 37;

    typedef struct packed {
        logic ovl_auto;    // overlap_time_mode_select: 1 automatic
        logic scheme_pw;   // exposure_scheme_select: 1 pulse_width_scheme
        logic pol_fall;    // edge_polarity_select: 0 activation_rise, 1 activation_fall
        logic src_ext;     // trigger_input_select: 1 external line
        logic trig_on;     // trigger_on_off
    } hte_ctrl_s;

    localparam hte_ctrl_s CTRL_RST = '0;

    typedef enum logic [1:0] {
        ST_WAIT = 2'b00,
        ST_EXPOSE = 2'b01,
        ST_OFFSET = 2'b11
    } hte_state_e;
endpackage : hte_pkg

// [hte_exposure_ctrl.sv]
// Exposure timing controller started by the external frame start trigger
`timescale 1ns/1ps
module hte_exposure_ctrl #(
    parameter bit HAS_GPIO = 1'b1,                          // Variant with general-purpose line
    parameter bit HAS_OFFSET = 1'b1,                        // Variant with sensor offset
    parameter int unsigned OFFSET_US = hte_pkg::OFFSET_US_DEF // Fixed exposure offset in us
) (
    input wire logic sys_clk_i,                                 // System clock
    input wire logic reset_n_i,                                 // Async reset, active low
    input wire logic ext_frame_start_trigger_i,                 // External trigger line
    input wire logic [hte_pkg::ADDR_W-1:0] reg_addr_i,          // Register address
    input wire logic [31:0] reg_wdata_i,                        // Write data
    input wire logic reg_wr_i,                                  // Write strobe
    input wire logic reg_rd_i,                                  // Read strobe
    output logic [31:0] reg_rdata_o,                            // Read data, cycle after strobe
    output logic exposure_active_o,                             // Sensor exposing
    output logic frame_trigger_wait_out_o,                      // Ready for next trigger
    output logic irq_o                                          // Level interrupt
);
    import hte_pkg::*;

    // ************************************************************
    // Reset release
    // ************************************************************
    logic rst_meta_r;
    logic rst_n;
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_meta_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n <= rst_meta_r;
        end
    end

    function automatic logic [DUR_W-1:0] at_least_one(input logic [DUR_W-1:0] v);
        return (v == '0) ? DUR_W'(1) : v;
    endfunction : at_least_one

    // ************************************************************
    // Registers
    // ************************************************************
    hte_ctrl_s ctrl_r;
    logic [DUR_W-1:0] exposure_duration_setting_r;
    logic [DUR_W-1:0] overlap_time_maximum_r;
    logic [PRESC_W-1:0] presc_r;
    logic [STAT_W-1:0] status_r;
    logic [STAT_W-1:0] mask_r;
    logic [STAT_W-1:0] events;
    hte_state_e state_r;
    hte_state_e state_nxt;
    hte_ctrl_s ctrl_wr;

    always_comb begin
        ctrl_wr = hte_ctrl_s'(reg_wdata_i[4:0]);
        // Selector absent without the general-purpose line
        ctrl_wr.ovl_auto = HAS_GPIO ? ctrl_wr.ovl_auto : 1'b0;
        // Pulse width needs mode and source already set
        if (HAS_GPIO && !(ctrl_r.trig_on && ctrl_r.src_ext)) begin
            ctrl_wr.scheme_pw = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= CTRL_RST;
            exposure_duration_setting_r <= EXPOSURE_RST;
            presc_r <= PRESC_RST;
            mask_r <= MASK_RST;
        end else if (reg_wr_i) begin
            if (reg_addr_i == OFS_CTRL) begin
                ctrl_r <= ctrl_wr;
            end else if (reg_addr_i == OFS_EXPOSURE) begin
                exposure_duration_setting_r <= reg_wdata_i[DUR_W-1:0];
            end else if (reg_addr_i == OFS_PRESCALE) begin
                presc_r <= reg_wdata_i[PRESC_W-1:0];
            end else if (reg_addr_i == OFS_MASK) begin
                mask_r <= reg_wdata_i[STAT_W-1:0];
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            overlap_time_maximum_r <= OVERLAP_MAX;
        end else if (ctrl_r.ovl_auto) begin
            overlap_time_maximum_r <= OVERLAP_MAX;
        end else if (reg_wr_i && reg_addr_i == OFS_OVERLAP) begin
            overlap_time_maximum_r <= reg_wdata_i[DUR_W-1:0];
        end
    end

    // Set beats the clearing read so no event is lost
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            status_r <= '0;
        end else if (reg_rd_i && reg_addr_i == OFS_STATUS) begin
            status_r <= events;
        end else begin
            status_r <= status_r | events;
        end
    end

    assign irq_o = |(status_r & mask_r);

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_o <= '0;
        end else if (reg_rd_i) begin
            if (reg_addr_i == OFS_CTRL) begin
                reg_rdata_o <= {27'h0, ctrl_r};
            end else if (reg_addr_i == OFS_EXPOSURE) begin
                reg_rdata_o <= {8'h0, exposure_duration_setting_r};
            end else if (reg_addr_i == OFS_OVERLAP) begin
                reg_rdata_o <= {8'h0, overlap_time_maximum_r};
            end else if (reg_addr_i == OFS_PRESCALE) begin
                reg_rdata_o <= {16'h0, presc_r};
            end else if (reg_addr_i == OFS_STATUS) begin
                reg_rdata_o <= {29'h0, status_r};
            end else if (reg_addr_i == OFS_MASK) begin
                reg_rdata_o <= {29'h0, mask_r};
            end else if (reg_addr_i == OFS_STATE) begin
                reg_rdata_o <= {29'h0, frame_trigger_wait_out_o, state_r == ST_WAIT, exposure_active_o};
            end else begin
                reg_rdata_o <= '0;
            end
        end else begin
            reg_rdata_o <= '0;
        end
    end

    // ************************************************************
    // Trigger synchroniser and edge detection
    // ************************************************************
    logic trig_meta_r;
    logic trig_sync_r;
    logic trig_prev_r;
    logic edge_rise;
    logic edge_fall;
    logic act_edge;
    logic opp_edge;
    logic hw_enabled;

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            trig_meta_r <= 1'b0;
            trig_sync_r <= 1'b0;
            trig_prev_r <= 1'b0;
        end else begin
            trig_meta_r <= ext_frame_start_trigger_i;
            trig_sync_r <= trig_meta_r;
            trig_prev_r <= trig_sync_r;
        end
    end

    assign edge_rise = trig_sync_r & ~trig_prev_r;
    assign edge_fall = ~trig_sync_r & trig_prev_r;
    assign act_edge = ctrl_r.pol_fall ? edge_fall : edge_rise;
    assign opp_edge = ctrl_r.pol_fall ? edge_rise : edge_fall;
    assign hw_enabled = ctrl_r.trig_on & ctrl_r.src_ext;

    // ************************************************************
    // Microsecond tick and exposure sequencer
    // ************************************************************
    logic [PRESC_W-1:0] presc_cnt_r;
    logic [DUR_W-1:0] cnt_r;
    logic [DUR_W-1:0] elapsed_r;
    logic tick;
    logic start;

    // Tick phase restarts with each exposure so the length is exact
    assign tick = (presc_cnt_r == presc_r);
    assign start = (state_r == ST_WAIT) && hw_enabled && act_edge;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_WAIT: begin
                if (start) begin
                    state_nxt = ST_EXPOSE;
                end
            end
            ST_EXPOSE: begin
                if (ctrl_r.scheme_pw) begin
                    if (opp_edge) begin
                        state_nxt = HAS_OFFSET ? ST_OFFSET : ST_WAIT;
                    end
                end else if (tick && cnt_r == DUR_W'(1)) begin
                    state_nxt = ST_WAIT;
                end
            end
            ST_OFFSET: begin
                if (tick && cnt_r == DUR_W'(1)) begin
                    state_nxt = ST_WAIT;
                end
            end
            default: begin
                state_nxt = ST_WAIT;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_WAIT;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            presc_cnt_r <= '0;
            cnt_r <= '0;
            elapsed_r <= '0;
        end else if (state_nxt != state_r) begin
            presc_cnt_r <= '0;
            elapsed_r <= '0;
            // Offset is loaded only at the end, start time is untouched
            cnt_r <= (state_nxt == ST_OFFSET) ? at_least_one(DUR_W'(OFFSET_US))
                                              : at_least_one(exposure_duration_setting_r);
        end else if (state_r != ST_WAIT) begin
            presc_cnt_r <= tick ? '0 : presc_cnt_r + PRESC_W'(1);
            if (tick) begin
                cnt_r <= cnt_r - DUR_W'(1);
                elapsed_r <= (elapsed_r == OVERLAP_MAX) ? elapsed_r : elapsed_r + DUR_W'(1);
            end
        end
    end

    assign events[STAT_OVERTRIG] = (state_r != ST_WAIT) && hw_enabled && act_edge;
    assign events[STAT_EXP_START] = start;
    assign events[STAT_EXP_END] = (state_r != ST_WAIT) && (state_nxt == ST_WAIT);

    // Overlap window lets the next trigger be armed before readout ends
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            exposure_active_o <= 1'b0;
            frame_trigger_wait_out_o <= 1'b0;
        end else begin
            exposure_active_o <= (state_nxt != ST_WAIT);
            frame_trigger_wait_out_o <= hw_enabled && ((state_nxt == ST_WAIT) ||
                (ctrl_r.scheme_pw && state_nxt == ST_EXPOSE && state_r == ST_EXPOSE &&
                 elapsed_r >= overlap_time_maximum_r));
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    logic [31:0] len_r;
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            len_r <= '0;
        end else if (state_nxt != state_r) begin
            len_r <= '0;
        end else begin
            len_r <= len_r + 32'h1;
        end
    end

    sequence s_active_edge_waiting;
        state_r == ST_WAIT && hw_enabled && act_edge;
    endsequence

    sequence s_exposing_next;
        ##1 (state_r == ST_EXPOSE && exposure_active_o);
    endsequence

    chk_start_on_edge: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
        s_active_edge_waiting |-> s_exposing_next)
        else $error("exposure did not start on active edge");

    chk_timed_exact_len: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
        (state_r == ST_EXPOSE && state_nxt == ST_WAIT && !ctrl_r.scheme_pw) |->
        (len_r + 32'h1 == 32'(at_least_one(exposure_duration_setting_r)) * (32'(presc_r) + 32'h1)))
        else $error("timed exposure length wrong");

    chk_offset_len: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
        (state_r == ST_OFFSET && state_nxt == ST_WAIT) |->
        (len_r + 32'h1 == 32'(OFFSET_US) * (32'(presc_r) + 32'h1)))
        else $error("offset period length wrong");

    chk_overtrig_flag: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
        (state_r != ST_WAIT && hw_enabled && act_edge) |=>
        status_r[STAT_OVERTRIG] && ($stable(state_r) || state_r != ST_EXPOSE))
        else $error("overtrigger not flagged or trigger not dropped");

    chk_pw_end_edge: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
        (state_r == ST_EXPOSE && ctrl_r.scheme_pw && opp_edge) |=>
        (state_r == (HAS_OFFSET ? ST_OFFSET : ST_WAIT)))
        else $error("pulse width exposure did not end on opposite edge");

    chk_disabled_idle: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
        (state_r == ST_WAIT && !hw_enabled) |=> state_r == ST_WAIT)
        else $error("exposure started without external trigger");

    chk_auto_overlap: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
        ctrl_r.ovl_auto |=> overlap_time_maximum_r == OVERLAP_MAX)
        else $error("overlap maximum not forced in automatic mode");

    chk_no_selector: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
        !HAS_GPIO |-> !ctrl_r.ovl_auto)
        else $error("overlap selector present without general-purpose line");

    chk_wait_ready: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
        (state_r == ST_WAIT && hw_enabled) [*2] |-> frame_trigger_wait_out_o)
        else $error("frame trigger wait low while waiting");

    chk_irq_level: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
        irq_o == |(status_r & mask_r))
        else $error("interrupt level mismatch");
endmodule : hte_exposure_ctrl

// [hte_trig_src.sv]
// Behavioural model of the external trigger source that drives the frame start line
`timescale 1ns/1ps
module hte_trig_src (
    input wire logic clk_i, // Clock the source is aligned to
    output logic trig_o     // Frame start trigger line
);
    initial begin
        trig_o = 1'b0;
    end

    // ************************************************************
    // Line control
    // ************************************************************
    // Only call this while triggering is disabled, or the move is seen as an edge
    task automatic set_rest(input logic lvl);
        @(posedge clk_i);
        trig_o <= lvl;
    endtask : set_rest

    // Width is the time the line stays at the active level, in clocks; in the pulse-width scheme, the wanted exposure minus the sensor offset
    task automatic pulse(input logic act, input int width);
        @(posedge clk_i);
        trig_o <= act;
        repeat (width) @(posedge clk_i);
        trig_o <= ~act;
    endtask : pulse
endmodule : hte_trig_src

// [test_hw_trigger_exposure_control.sv]
// Self-checking testbench of the exposure controller
`timescale 1ns/1ps
module test_hw_trigger_exposure_control;
    import hte_pkg::*;
    localparam int unsigned OFS_US = 5;
    localparam int unsigned DUR = 20;
    localparam int unsigned PW = 30;
    // Pin to exposure start: two synchroniser stages and the exposure_active_o register
    localparam int unsigned LAT = 3;
    logic sys_clk_i;
    logic reset_n_i;
    logic trig;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic [31:0] rdata;
    logic expo;
    logic fwait;
    logic irq;
    int failures = 0;
    int total_checks = 0;
    int lat;
    int len;

    hte_trig_src src (.clk_i(sys_clk_i), .trig_o(trig));

    hte_exposure_ctrl #(.HAS_GPIO(1'b1), .HAS_OFFSET(1'b1), .OFFSET_US(OFS_US)) uut (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .ext_frame_start_trigger_i(trig),
        .reg_addr_i(addr),
        .reg_wdata_i(wdata),
        .reg_wr_i(wr),
        .reg_rd_i(rd),
        .reg_rdata_o(rdata),
        .exposure_active_o(expo),
        .frame_trigger_wait_out_o(fwait),
        .irq_o(irq)
    );

    initial begin
        sys_clk_i = 1'b0;
        forever #2.5 sys_clk_i = ~sys_clk_i;
    end

    // ************************************************************
    // Helpers
    // ************************************************************
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge sys_clk_i);
        wr <= 1'b0;
    endtask : wr_reg

    // Read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        @(posedge sys_clk_i);
        rd <= 1'b1;
        addr <= a;
        @(posedge sys_clk_i);
        rd <= 1'b0;
        #1;
        check(rdata, exp);
    endtask : rd_chk

    // Clocks from the launching edge to exposure start, sampled on falling edges
    task automatic wait_start(output int l);
        @(posedge sys_clk_i);
        l = 0;
        while (expo !== 1'b1 && l < 40) begin
            @(negedge sys_clk_i);
            if (expo !== 1'b1) begin
                l++;
            end
        end
    endtask : wait_start

    task automatic measure(output int l, output int n);
        wait_start(l);
        n = 0;
        while (expo === 1'b1 && n < 200) begin
            n++;
            @(negedge sys_clk_i);
        end
    endtask : measure

    task automatic summarize();
        $display("checks=%0d failures=%0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize

    // ************************************************************
    // Watchdog, well beyond the few hundred cycles the tests need
    // ************************************************************
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        failures++;
        summarize();
    end

    // ************************************************************
    // Tests
    // ************************************************************
    initial begin
        reset_n_i = 1'b0;
        addr = '0;
        wdata = '0;
        wr = 1'b0;
        rd = 1'b0;
        repeat (6) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        rd_chk(OFS_CTRL, 32'(CTRL_RST));
        rd_chk(OFS_EXPOSURE, 32'(EXPOSURE_RST));
        rd_chk(OFS_OVERLAP, 32'(OVERLAP_MAX));
        rd_chk(OFS_PRESCALE, 32'(PRESC_RST));
        rd_chk(OFS_STATUS, 32'h0);
        rd_chk(OFS_MASK, 32'(MASK_RST));
        rd_chk(8'h1c, 32'h0);
        // One clock per microsecond keeps every count short
        wr_reg(OFS_PRESCALE, 32'h0);
        wr_reg(OFS_EXPOSURE, 32'(DUR));
        wr_reg(OFS_CTRL, 32'h08);
        rd_chk(OFS_CTRL, 32'h0);
        wr_reg(OFS_CTRL, 32'h01);
        fork src.pulse(1'b1, 5); measure(lat, len); join
        check(32'(len), 32'h0);
        rd_chk(OFS_STATUS, 32'h0);
        wr_reg(OFS_CTRL, 32'h03);
        rd_chk(OFS_STATE, 32'h6);
        fork src.pulse(1'b1, 5); measure(lat, len); join
        check(32'(lat), 32'(LAT));
        check(32'(len), 32'(DUR));
        check(32'(irq), 32'h0);
        rd_chk(OFS_STATUS, 32'h6);
        wr_reg(OFS_MASK, 32'h1);
        fork
            begin
                src.pulse(1'b1, 3);
                repeat (3) @(posedge sys_clk_i);
                src.pulse(1'b1, 3);
            end
            measure(lat, len);
        join
        check(32'(len), 32'(DUR));
        check(32'(irq), 32'h1);
        rd_chk(OFS_STATUS, 32'h7);
        check(32'(irq), 32'h0);
        wr_reg(OFS_CTRL, 32'h0);
        src.set_rest(1'b1);
        wr_reg(OFS_CTRL, 32'h07);
        fork src.pulse(1'b0, 5); measure(lat, len); join
        check(32'(lat), 32'(LAT));
        check(32'(len), 32'(DUR));
        wr_reg(OFS_CTRL, 32'h0f);
        fork src.pulse(1'b0, PW); measure(lat, len); join
        check(32'(lat), 32'(LAT));
        check(32'(len), 32'(PW + OFS_US));
        wr_reg(OFS_CTRL, 32'h0);
        src.set_rest(1'b0);
        wr_reg(OFS_CTRL, 32'h03);
        wr_reg(OFS_CTRL, 32'h0b);
        wr_reg(OFS_OVERLAP, 32'(PW));
        rd_chk(OFS_OVERLAP, 32'(PW));
        wr_reg(OFS_CTRL, 32'h1b);
        rd_chk(OFS_OVERLAP, 32'(OVERLAP_MAX));
        wr_reg(OFS_OVERLAP, 32'h5);
        rd_chk(OFS_OVERLAP, 32'(OVERLAP_MAX));
        wr_reg(OFS_CTRL, 32'h0b);
        wr_reg(OFS_OVERLAP, 32'(PW));
        fork src.pulse(1'b1, PW); measure(lat, len); join
        check(32'(len), 32'(PW + OFS_US));
        // Pulse outlasts the overlap time so wait rises while still exposing
        fork
            src.pulse(1'b1, PW + 5);
            begin
                wait_start(lat);
                check(32'(fwait), 32'h0);
                repeat (PW - 2) @(negedge sys_clk_i);
                check(32'(fwait), 32'h0);
                repeat (5) @(negedge sys_clk_i);
                check(32'(expo), 32'h1);
                check(32'(fwait), 32'h1);
            end
        join
        repeat (20) @(negedge sys_clk_i);
        check(32'(fwait), 32'h1);
        summarize();
    end
endmodule : test_hw_trigger_exposure_control
